// file: include/sawc_pkg.sv
/*
  Shared constants and types for the synchronous SRAM address capture and
  write-qualification block. Assumes a single clock domain and an
  asynchronous active-high reset in every file that uses it.
*/
// Notes on behaviour
// - Capture address on strobe with chips selected.
// - Captured low two address bits load burst counter.
// - Lane select writes only with byte-write enable low.
// - Global write low writes every lane.
// - Both strobes low: processor strobe wins.
// - Lane select covers eight data bits and parity.
package sawc_pkg;

  // -------------------------------------------------------------------
  // Geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W_DEF  = 19;
  localparam int LANES_DEF   = 4;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W      = LANE_DATA_W + 1;
  localparam int BURST_W     = 2;
  localparam int BURST_LSB   = 0;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [1:0] BURST_RST = 2'h0;

  // -------------------------------------------------------------------
  // Cycle kinds
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    SAWC_IDLE   = 4'h1,
    SAWC_READ   = 4'h2,
    SAWC_LANE_W = 4'h4,
    SAWC_ALL_W  = 4'h8
  } sawc_op_t;

  // -------------------------------------------------------------------
  // Which strobe started the captured access
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    SAWC_SRC_PROC = 2'h1,
    SAWC_SRC_CTRL = 2'h2
  } sawc_src_t;

endpackage

// file: hdl/sawc_sync.sv
/*
  Two-flop synchroniser bank for pins entering the clock domain.
  Assumes the first stage is read by the second stage only.
*/
`timescale 1ns/1ps
module sawc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  // Reset clears both stages. The caller stores active-low pins inverted, so
  // a cleared stage reads back as the inactive level once rst_val is applied.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2 ^ rst_val;

endmodule

// file: hdl/sawc_top.sv
/*
  Address capture, burst start and byte-lane write decode of a pipelined
  synchronous burst SRAM. Assumes every pin is driven by a controller on
  another clock, so all pins are synchronised before use.
*/
`timescale 1ns/1ps
module sawc_top #(
  parameter int ADDR_W = sawc_pkg::ADDR_W_DEF,
  parameter int LANES  = sawc_pkg::LANES_DEF
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [ADDR_W-1:0]              addr_in,
  input  wire logic                           proc_addr_strobe_n,
  input  wire logic                           ctrl_addr_strobe_n,
  input  wire logic                           chip_sel1_n,
  input  wire logic                           chip_sel2,
  input  wire logic                           chip_sel3_n,
  input  wire logic [LANES-1:0]               lane_wr_sel_n,
  input  wire logic                           lane_write_enable_n,
  input  wire logic                           all_lanes_write_n,
  output logic      [ADDR_W-1:0]              addr_reg,
  output logic      [sawc_pkg::BURST_W-1:0]   burst_count,
  output logic                                addr_valid,
  output logic                                from_proc,
  output logic      [LANES-1:0]               lane_wr_en,
  output logic      [LANES*sawc_pkg::LANE_W-1:0] bit_wr_mask,
  output logic                                is_write,
  output logic                                is_read
);

  // -------------------------------------------------------------------
  // Pin synchronisation
  // -------------------------------------------------------------------
  // Each pin is synchronised on its own, so an address that changes within
  // one clock of a strobe could be captured torn. The controller must hold
  // address, strobes and selects steady together across the sampling edge.
  localparam int SW = ADDR_W + 7 + LANES;

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_inv;
  logic [SW-1:0] pins;

  assign pins_raw = {addr_in, proc_addr_strobe_n, ctrl_addr_strobe_n, chip_sel1_n,
                     chip_sel2, chip_sel3_n, lane_write_enable_n, all_lanes_write_n,
                     lane_wr_sel_n};
  // Active-low pins idle high after reset, others idle low.
  assign pins_inv = {{ADDR_W{1'b0}}, 3'h7, 1'b0, 3'h7, {LANES{1'b1}}};

  sawc_sync #(.W(SW)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .din     (pins_raw ^ pins_inv),
    .rst_val (pins_inv),
    .dout    (pins)
  );

  logic [ADDR_W-1:0] s_addr;
  logic              s_psn;
  logic              s_csn;
  logic              s_cs1n;
  logic              s_cs2;
  logic              s_cs3n;
  logic              s_bwen;
  logic              s_gwn;
  logic [LANES-1:0]  s_sel_n;

  assign {s_addr, s_psn, s_csn, s_cs1n, s_cs2, s_cs3n, s_bwen, s_gwn, s_sel_n} = pins;

  // -------------------------------------------------------------------
  // Qualification
  // -------------------------------------------------------------------
  function automatic logic chips_on(input logic c1n, input logic c2, input logic c3n);
    return !c1n && c2 && !c3n;
  endfunction

  // Spreads each lane enable over its eight data bits and its parity bit.
  function automatic logic [LANES*sawc_pkg::LANE_W-1:0] lane_mask(input logic [LANES-1:0] en);
    lane_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_mask[i*sawc_pkg::LANE_W +: sawc_pkg::LANE_W] = {sawc_pkg::LANE_W{en[i]}};
    end
  endfunction

  logic              sel_ok;
  logic              take;
  sawc_pkg::sawc_src_t src;
  sawc_pkg::sawc_op_t  op;
  logic [LANES-1:0]  lanes;

  always_comb begin
    sel_ok = chips_on(s_cs1n, s_cs2, s_cs3n);
    take   = sel_ok && (!s_psn || !s_csn);
    src    = !s_psn ? sawc_pkg::SAWC_SRC_PROC : sawc_pkg::SAWC_SRC_CTRL;
    lanes  = '0;
    op     = sawc_pkg::SAWC_IDLE;
    if (!s_gwn) begin
      lanes = '1;
      op    = sawc_pkg::SAWC_ALL_W;
    end else if (!s_bwen && (s_sel_n != '1)) begin
      lanes = ~s_sel_n;
      op    = sawc_pkg::SAWC_LANE_W;
    end else begin
      op    = sawc_pkg::SAWC_READ;
    end
  end

  // -------------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------------
  logic [ADDR_W-1:0]                next_addr_reg;
  logic [sawc_pkg::BURST_W-1:0]     next_burst;
  logic                             next_valid;
  logic                             next_from_proc;
  logic [LANES-1:0]                 next_lane_wr_en;
  logic [LANES*sawc_pkg::LANE_W-1:0] next_mask;
  logic                             next_is_write;
  logic                             next_is_read;

  always_comb begin
    next_addr_reg   = addr_reg;
    next_burst      = burst_count;
    next_from_proc  = from_proc;
    next_valid      = take;
    if (take) begin
      next_addr_reg  = s_addr;
      next_burst     = s_addr[sawc_pkg::BURST_LSB +: sawc_pkg::BURST_W];
      next_from_proc = (src == sawc_pkg::SAWC_SRC_PROC);
    end
    next_lane_wr_en = lanes;
    // Classification runs every cycle, independent of any capture.
    next_mask       = lane_mask(lanes);
    next_is_write = (op == sawc_pkg::SAWC_ALL_W) || (op == sawc_pkg::SAWC_LANE_W);
    next_is_read  = (op == sawc_pkg::SAWC_READ);
  end

  // Captured fields hold between captures; per-cycle fields refresh each edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg    <= '0;
      burst_count <= sawc_pkg::BURST_RST;
      addr_valid  <= 1'b0;
      from_proc   <= 1'b0;
      lane_wr_en  <= '0;
      bit_wr_mask <= '0;
      is_write    <= 1'b0;
      is_read     <= 1'b0;
    end else begin
      addr_reg    <= next_addr_reg;
      burst_count <= next_burst;
      addr_valid  <= next_valid;
      from_proc   <= next_from_proc;
      lane_wr_en  <= next_lane_wr_en;
      bit_wr_mask <= next_mask;
      is_write    <= next_is_write;
      is_read     <= next_is_read;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  // Each check that reads pins reads the synchronised pins, the same view the logic uses.
  localparam int LANE_W_TOP = sawc_pkg::LANE_W - 1;

  a_capture_qual: assert property (@(posedge clk) disable iff (rst)
    addr_valid |-> $past(sel_ok) && !($past(s_psn) && $past(s_csn)))
    else $error("Address captured without qualification.");
  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    !take |=> $stable(addr_reg))
    else $error("Address changed without a capture.");
  a_burst_load: assert property (@(posedge clk) disable iff (rst)
    take |=> burst_count == $past(s_addr[sawc_pkg::BURST_LSB +: sawc_pkg::BURST_W]))
    else $error("Burst counter not loaded from address.");
  a_lane_gate: assert property (@(posedge clk) disable iff (rst)
    (s_gwn && s_bwen) |=> lane_wr_en == '0)
    else $error("Lane written without byte-write enable.");
  a_lane_sel: assert property (@(posedge clk) disable iff (rst)
    (s_gwn && !s_bwen) |=> lane_wr_en == ~$past(s_sel_n))
    else $error("Lane write does not follow selects.");
  a_global_all: assert property (@(posedge clk) disable iff (rst)
    !s_gwn |=> lane_wr_en == '1 && is_write)
    else $error("Global write missed a lane.");
  a_proc_wins: assert property (@(posedge clk) disable iff (rst)
    (take && !s_psn && !s_csn) |=> from_proc)
    else $error("Controller strobe taken over processor strobe.");
  a_parity_lane: assert property (@(posedge clk) disable iff (rst)
    bit_wr_mask[LANE_W_TOP] == lane_wr_en[0])
    else $error("Parity bit mask differs from lane.");
  a_read_none: assert property (@(posedge clk) disable iff (rst)
    is_read |-> lane_wr_en == '0 && !is_write)
    else $error("Read cycle modified a lane.");

  // Pins feed these checks one cycle before the registered outputs that
  // they govern, so most of them use the next-cycle implication.
  a_capture_load: assert property (@(posedge clk) disable iff (rst)
    take |=> addr_valid && addr_reg == $past(s_addr))
    else $error("Qualified strobe did not capture the address.");
  a_burst_hold: assert property (@(posedge clk) disable iff (rst)
    !take |=> $stable(burst_count) && $stable(from_proc))
    else $error("Burst start changed without a capture.");
  a_lane_write: assert property (@(posedge clk) disable iff (rst)
    (s_gwn && !s_bwen && s_sel_n != '1) |=> is_write && !is_read)
    else $error("Selected lane write not flagged as write.");
  a_ctrl_only: assert property (@(posedge clk) disable iff (rst)
    (take && s_psn) |=> !from_proc)
    else $error("Controller capture marked as processor capture.");
  a_class_one: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> is_write != is_read)
    else $error("Cycle classified as neither or both read and write.");

  for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
    a_lane_mask: assert property (@(posedge clk) disable iff (rst)
      bit_wr_mask[g*sawc_pkg::LANE_W +: sawc_pkg::LANE_W] == {sawc_pkg::LANE_W{lane_wr_en[g]}})
      else $error("Lane mask bits differ from lane enable.");
  end

  c_proc_cap: cover property (@(posedge clk) disable iff (rst) take && !s_psn);
  c_ctrl_cap: cover property (@(posedge clk) disable iff (rst) take && s_psn);
  c_lane_wr:  cover property (@(posedge clk) disable iff (rst) is_write && lane_wr_en != '1);
  c_all_wr:   cover property (@(posedge clk) disable iff (rst) is_write && lane_wr_en == '1);
  c_read_cyc: cover property (@(posedge clk) disable iff (rst) is_read && addr_valid);

endmodule

// file: bench/sawc_ctrl_model.sv
/*
  Model of the bus controller that drives the SRAM input pins.
  Assumes the bench changes request fields just after a rising edge.
*/
`timescale 1ns/1ps
module sawc_ctrl_model (
  input  wire logic        rq_proc,
  input  wire logic        rq_ctrl,
  input  wire logic [2:0]  rq_desel,
  input  wire logic [18:0] rq_addr,
  input  wire logic [3:0]  rq_lanes,
  input  wire logic        rq_lane_wr,
  input  wire logic        rq_all_wr,
  output logic      [18:0] addr_in,
  output logic             proc_addr_strobe_n,
  output logic             ctrl_addr_strobe_n,
  output logic             chip_sel1_n,
  output logic             chip_sel2,
  output logic             chip_sel3_n,
  output logic      [3:0]  lane_wr_sel_n,
  output logic             lane_write_enable_n,
  output logic             all_lanes_write_n
);
  always_comb begin
    addr_in             = rq_addr;
    proc_addr_strobe_n  = ~rq_proc;
    ctrl_addr_strobe_n  = ~rq_ctrl;
    chip_sel1_n         = rq_desel[0];
    chip_sel2           = ~rq_desel[1];
    chip_sel3_n         = rq_desel[2];
    lane_wr_sel_n       = ~rq_lanes;
    lane_write_enable_n = ~rq_lane_wr;
    all_lanes_write_n   = ~rq_all_wr;
  end
endmodule

// file: bench/test_sync_sram_addr_write_ctrl.sv
/*
  Self-checking bench for address capture and lane write decode.
  Assumes default sizes and a three-edge pin-to-output latency.
*/
`timescale 1ns/1ps
module test_sync_sram_addr_write_ctrl;
  typedef struct packed {
    logic [31:0] due;
    logic        valid;
    logic [18:0] addr;
    logic        proc;
    logic [3:0]  lanes;
    logic        wr;
  } sawc_note_t;
  logic        clk, rst, rq_proc, rq_ctrl, rq_lane_wr, rq_all_wr, held_proc;
  logic [2:0]  rq_desel;
  logic [18:0] rq_addr, held_addr, addr_in, addr_reg;
  logic [3:0]  rq_lanes, lane_wr_sel_n, lane_wr_en;
  logic        ps_n, cs_n, c1_n, c2, c3_n, lwe_n, alw_n;
  logic [1:0]  burst_count;
  logic        addr_valid, from_proc, is_write, is_read;
  logic [35:0] bit_wr_mask;
  sawc_note_t  notes[$];
  sawc_note_t  mon_n;
  int          mismatches, checks_done, cyc, i;
  integer      seed = 32'hddbe3d71;
  sawc_ctrl_model sawc_ctrl_model_i (.rq_proc(rq_proc), .rq_ctrl(rq_ctrl), .rq_desel(rq_desel),
    .rq_addr(rq_addr), .rq_lanes(rq_lanes), .rq_lane_wr(rq_lane_wr), .rq_all_wr(rq_all_wr),
    .addr_in(addr_in), .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n),
    .chip_sel1_n(c1_n), .chip_sel2(c2), .chip_sel3_n(c3_n), .lane_wr_sel_n(lane_wr_sel_n),
    .lane_write_enable_n(lwe_n), .all_lanes_write_n(alw_n));
  sawc_top sawc_top_i (.clk(clk), .rst(rst), .addr_in(addr_in), .proc_addr_strobe_n(ps_n),
    .ctrl_addr_strobe_n(cs_n), .chip_sel1_n(c1_n), .chip_sel2(c2), .chip_sel3_n(c3_n),
    .lane_wr_sel_n(lane_wr_sel_n), .lane_write_enable_n(lwe_n), .all_lanes_write_n(alw_n),
    .addr_reg(addr_reg), .burst_count(burst_count), .addr_valid(addr_valid),
    .from_proc(from_proc), .lane_wr_en(lane_wr_en), .bit_wr_mask(bit_wr_mask),
    .is_write(is_write), .is_read(is_read));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [35:0] mask_of(input logic [3:0] l);
    for (int k = 0; k < 4; k++) mask_of[9*k +: 9] = {9{l[k]}};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ------------------------------------------------------------
  // One request per call; the expected outputs are queued.
  // ------------------------------------------------------------
  task automatic drive(input logic p, input logic c, input logic [2:0] ds,
                       input logic [18:0] a, input logic [3:0] ln, input logic lw,
                       input logic aw);
    sawc_note_t n;
    @(posedge clk);
    {rq_proc, rq_ctrl, rq_desel, rq_addr} <= {p, c, ds, a};
    {rq_lanes, rq_lane_wr, rq_all_wr} <= {ln, lw, aw};
    n.valid = (p | c) & (ds == 3'h0);
    if (n.valid) begin
      held_addr = a;
      held_proc = p;
    end
    n.due = cyc + 4;
    n.addr = held_addr;
    n.proc = held_proc;
    n.lanes = aw ? 4'hf : (lw ? ln : 4'h0);
    n.wr = aw | (lw & (ln != 4'h0));
    notes.push_back(n);
  endtask
  always @(negedge clk) begin
    if (!rst && notes.size() > 0 && notes[0].due <= cyc) begin
      mon_n = notes.pop_front();
      check(addr_valid, mon_n.valid);
      check(addr_reg, mon_n.addr);
      check(burst_count, mon_n.addr[1:0]);
      check(from_proc, mon_n.proc);
      check(lane_wr_en, mon_n.lanes);
      check(bit_wr_mask, mask_of(mon_n.lanes));
      check(is_write, mon_n.wr);
      check(is_read, !mon_n.wr);
    end
  end
  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rq_proc, rq_ctrl, rq_desel, rq_addr, rq_lanes, rq_lane_wr, rq_all_wr} = '0;
    {held_addr, held_proc} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    drive(1'b1, 1'b1, 3'h0, 19'h7fffe, 4'h0, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) drive(1'b1, 1'b1, 3'h1 << i, 19'h12345, 4'h0, 1'b0, 1'b0);
    drive(1'b0, 1'b1, 3'h0, 19'h00003, 4'ha, 1'b1, 1'b0);
    drive(1'b0, 1'b0, 3'h0, 19'h00001, 4'h5, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 3'h0, 19'h00002, 4'h0, 1'b1, 1'b1);
    drive(1'b0, 1'b0, 3'h0, 19'h00002, 4'h0, 1'b1, 1'b0);
    for (i = 0; i < 600; i++) begin
      drive($random(seed), $random(seed), $random(seed) & $random(seed) & $random(seed),
            $random(seed), $random(seed), $random(seed), $random(seed) & $random(seed));
    end
    for (i = 0; i < 20 && notes.size() > 0; i++) @(posedge clk);
    if (notes.size() > 0) mismatches++;
    give_verdict();
  end
endmodule
